// >>> vism_mapper.sv
// APB register file and routing of virtual input bits onto drive functions
`timescale 1ns/1ps
module vism_mapper (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [vism_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [vism_pkg::VIRT_BITS-1:0] virt_in,
  output logic      [vism_pkg::NUM_FUNC-1:0] func_out
);

  //----------------------------------------------------------------
  // Bus handshake
  //----------------------------------------------------------------
  vism_pkg::vism_cfg_t                 cfg_reg;
  logic [vism_pkg::NUM_FUNC-1:0]       func_next;
  logic [vism_pkg::VIRT_BITS-1:0]      level_next;
  logic [vism_pkg::VIRT_BITS-1:0]      inv_all;
  logic [31:0]                         rdata_next;
  logic                                addr_hit;
  logic                                addr_ro;
  logic                                access;
  logic                                wr_ok;

  // One wait state: pready rises on the second access cycle
  assign access = psel & penable & pready;
  assign wr_ok  = access & pwrite & addr_hit & ~addr_ro;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  //----------------------------------------------------------------
  // Address decode and read mux
  //----------------------------------------------------------------
  always_comb begin
    addr_hit   = 1'b1;
    addr_ro    = 1'b0;
    rdata_next = 32'h00000000;
    case (paddr)
      vism_pkg::OFS_PORT_ONE_SEL: begin
        rdata_next = cfg_reg.port_one_function_select;
      end
      vism_pkg::OFS_PORT_TWO_SEL: begin
        rdata_next = cfg_reg.port_two_function_select;
      end
      vism_pkg::OFS_LOWER_INV: begin
        rdata_next[3:0] = cfg_reg.lower_bits_invert_select;
      end
      vism_pkg::OFS_UPPER_INV: begin
        rdata_next[3:0] = cfg_reg.upper_bits_invert_select;
      end
      vism_pkg::OFS_FUNC_STATUS: begin
        addr_ro = 1'b1;
        rdata_next[vism_pkg::NUM_FUNC-1:0] = func_out;
      end
      vism_pkg::OFS_VIRT_STATUS: begin
        addr_ro = 1'b1;
        rdata_next[vism_pkg::VIRT_BITS-1:0] = virt_in;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Read data and error are loaded with the rising pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata  <= pwrite ? 32'h00000000 : rdata_next;
      pslverr <= ~addr_hit | (pwrite & addr_ro);
    end else begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Setting registers
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg.port_one_function_select <= vism_pkg::RST_PORT_ONE_SEL;
      cfg_reg.port_two_function_select <= vism_pkg::RST_PORT_TWO_SEL;
      cfg_reg.lower_bits_invert_select <= vism_pkg::RST_LOWER_INV;
      cfg_reg.upper_bits_invert_select <= vism_pkg::RST_UPPER_INV;
    end else if (wr_ok) begin
      case (paddr)
        vism_pkg::OFS_PORT_ONE_SEL: begin
          cfg_reg.port_one_function_select <= pwdata;
        end
        vism_pkg::OFS_PORT_TWO_SEL: begin
          cfg_reg.port_two_function_select <= pwdata;
        end
        vism_pkg::OFS_LOWER_INV: begin
          cfg_reg.lower_bits_invert_select <= pwdata[3:0];
        end
        vism_pkg::OFS_UPPER_INV: begin
          cfg_reg.upper_bits_invert_select <= pwdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // Routing
  //----------------------------------------------------------------
  assign inv_all    = {cfg_reg.upper_bits_invert_select, cfg_reg.lower_bits_invert_select};
  assign level_next = virt_in ^ inv_all;

  // Codes above the table select nothing; unselected functions stay low
  always_comb begin
    logic [63:0] codes;
    codes     = {cfg_reg.port_two_function_select, cfg_reg.port_one_function_select};
    func_next = '0;
    for (int i = 0; i < vism_pkg::VIRT_BITS; i++) begin
      for (int f = 0; f < vism_pkg::NUM_FUNC; f++) begin
        if (codes[i*vism_pkg::CODE_W +: vism_pkg::CODE_W] == 8'(f)) begin
          func_next[f] = func_next[f] | level_next[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_out <= '0;
    end else begin
      func_out <= func_next;
    end
  end

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  logic [7:0] c0;
  logic [7:0] c1;
  logic [7:0] c4;
  logic       only_c0_servo;
  logic       only_c1_mode;
  logic       only_c4_ot;
  logic       no_alarm_code;

  assign c0 = cfg_reg.port_one_function_select[7:0];
  assign c1 = cfg_reg.port_one_function_select[15:8];
  assign c4 = cfg_reg.port_two_function_select[7:0];

  function automatic logic count_code(input logic [63:0] w, input logic [7:0] code, input int skip);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < vism_pkg::VIRT_BITS; k++) begin
      if (k != skip && w[k*8 +: 8] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  assign only_c0_servo = (c0 == vism_pkg::FN_SERVO_ON) &&
    !count_code({cfg_reg.port_two_function_select, cfg_reg.port_one_function_select}, vism_pkg::FN_SERVO_ON, 0);
  assign only_c1_mode  = (c1 == vism_pkg::FN_CONTROL_MODE) &&
    !count_code({cfg_reg.port_two_function_select, cfg_reg.port_one_function_select}, vism_pkg::FN_CONTROL_MODE, 1);
  assign only_c4_ot    = (c4 == vism_pkg::FN_POS_OVERTRAVEL) &&
    !count_code({cfg_reg.port_two_function_select, cfg_reg.port_one_function_select},
                vism_pkg::FN_POS_OVERTRAVEL, 4);
  assign no_alarm_code =
    !count_code({cfg_reg.port_two_function_select, cfg_reg.port_one_function_select}, vism_pkg::FN_ALARM_CLEAR, 99);

  sequence s_wr_port_one;
    psel && penable && pready && pwrite && paddr == vism_pkg::OFS_PORT_ONE_SEL;
  endsequence

  sequence s_wr_port_two;
    psel && penable && pready && pwrite && paddr == vism_pkg::OFS_PORT_TWO_SEL;
  endsequence

  property p_port_one_store;
    @(posedge pclk) disable iff (!presetn)
    s_wr_port_one |=> cfg_reg.port_one_function_select == $past(pwdata);
  endproperty
  a_port_one_store: assert property (p_port_one_store) else $error("port one word not stored");

  property p_code_servo;
    @(posedge pclk) disable iff (!presetn)
    only_c0_servo |=> func_out[0] == $past(virt_in[0] ^ cfg_reg.lower_bits_invert_select[0]);
  endproperty
  a_code_servo: assert property (p_code_servo) else $error("code 00 not routed from bit8");

  property p_code_mode;
    @(posedge pclk) disable iff (!presetn)
    only_c1_mode |=> func_out[1] == $past(virt_in[1] ^ cfg_reg.lower_bits_invert_select[1]);
  endproperty
  a_code_mode: assert property (p_code_mode) else $error("code 01 not routed from bit9");

  property p_port_two_route;
    @(posedge pclk) disable iff (!presetn)
    s_wr_port_two ##1 only_c4_ot |=> func_out[2] == $past(virt_in[4] ^ cfg_reg.upper_bits_invert_select[0]);
  endproperty
  a_port_two_route: assert property (p_port_two_route) else $error("port two code not routed");

  property p_inv_width;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !pwrite && paddr == vism_pkg::OFS_LOWER_INV |=> prdata[31:4] == 28'h0000000;
  endproperty
  a_inv_width: assert property (p_inv_width) else $error("lower inversion reads wider than four bits");

  property p_inv_flip_low;
    @(posedge pclk) disable iff (!presetn)
    only_c0_servo && $stable(virt_in) && $changed(cfg_reg.lower_bits_invert_select[0]) |=>
      $changed(func_out[0]);
  endproperty
  a_inv_flip_low: assert property (p_inv_flip_low) else $error("bit8 inversion has no effect");

  property p_inv_bit11;
    @(posedge pclk) disable iff (!presetn)
    cfg_reg.port_one_function_select[31:24] == vism_pkg::FN_ANALOG_SELECT &&
      virt_in[3] != cfg_reg.lower_bits_invert_select[3] |=> func_out[26];
  endproperty
  a_inv_bit11: assert property (p_inv_bit11) else $error("bit11 level not presented");

  property p_inv_upper;
    @(posedge pclk) disable iff (!presetn)
    only_c4_ot && virt_in[4] == cfg_reg.upper_bits_invert_select[0] |=> !func_out[2];
  endproperty
  a_inv_upper: assert property (p_inv_upper) else $error("bit12 inversion wrong");

  property p_unselected_idle;
    @(posedge pclk) disable iff (!presetn)
    no_alarm_code [*2] |-> !func_out[4];
  endproperty
  a_unselected_idle: assert property (p_unselected_idle) else $error("unselected function active");

  //----------------------------------------------------------------
  // Bus and setting checks
  //----------------------------------------------------------------
  sequence s_wr_lower;
    psel && penable && pready && pwrite && paddr == vism_pkg::OFS_LOWER_INV;
  endsequence

  sequence s_wr_upper;
    psel && penable && pready && pwrite && paddr == vism_pkg::OFS_UPPER_INV;
  endsequence

  property p_port_two_store;
    @(posedge pclk) disable iff (!presetn)
    s_wr_port_two |=> cfg_reg.port_two_function_select == $past(pwdata);
  endproperty
  a_port_two_store: assert property (p_port_two_store) else $error("port two word not stored");

  property p_lower_store;
    @(posedge pclk) disable iff (!presetn)
    s_wr_lower |=> cfg_reg.lower_bits_invert_select == $past(pwdata[3:0]);
  endproperty
  a_lower_store: assert property (p_lower_store) else $error("lower inversion not stored");

  property p_upper_store;
    @(posedge pclk) disable iff (!presetn)
    s_wr_upper |=> cfg_reg.upper_bits_invert_select == $past(pwdata[3:0]);
  endproperty
  a_upper_store: assert property (p_upper_store) else $error("upper inversion not stored");

  property p_settings_hold;
    @(posedge pclk) disable iff (!presetn)
    !wr_ok |=> $stable(cfg_reg);
  endproperty
  a_settings_hold: assert property (p_settings_hold) else $error("settings changed without a write");

  property p_wait_state;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("access not answered after one wait state");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held longer than one cycle");

  property p_idle_quiet;
    @(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h00000000 && !pslverr;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("read data or error shown outside ready");

  property p_refused_addr;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !addr_hit |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_refused_addr: assert property (p_refused_addr) else $error("unmapped access not refused");

endmodule

// >>> vism_pkg.sv
// Constants and types of the virtual input signal mapper
package vism_pkg;

  //----------------------------------------------------------------
  // Register map, byte addresses
  //----------------------------------------------------------------
  localparam int          ADDR_W            = 8;
  localparam logic [7:0]  OFS_PORT_ONE_SEL  = 8'h00;
  localparam logic [7:0]  OFS_PORT_TWO_SEL  = 8'h04;
  localparam logic [7:0]  OFS_LOWER_INV     = 8'h08;
  localparam logic [7:0]  OFS_UPPER_INV     = 8'h0C;
  localparam logic [7:0]  OFS_FUNC_STATUS   = 8'h10;
  localparam logic [7:0]  OFS_VIRT_STATUS   = 8'h14;

  //----------------------------------------------------------------
  // Reset values and field layout
  //----------------------------------------------------------------
  localparam logic [31:0] RST_PORT_ONE_SEL  = 32'h13121110;
  localparam logic [31:0] RST_PORT_TWO_SEL  = 32'h0F0E0D0C;
  localparam logic [3:0]  RST_LOWER_INV     = 4'h0;
  localparam logic [3:0]  RST_UPPER_INV     = 4'h0;
  localparam int          CODE_W            = 8;
  localparam int          BITS_PER_PORT     = 4;
  localparam int          VIRT_BITS         = 8;
  localparam int          NUM_FUNC          = 27;
  localparam logic [7:0]  CODE_MAX          = 8'h1A;

  //----------------------------------------------------------------
  // Function codes used by name
  //----------------------------------------------------------------
  localparam logic [7:0]  FN_SERVO_ON       = 8'h00;
  localparam logic [7:0]  FN_CONTROL_MODE   = 8'h01;
  localparam logic [7:0]  FN_POS_OVERTRAVEL = 8'h02;
  localparam logic [7:0]  FN_ALARM_CLEAR    = 8'h04;
  localparam logic [7:0]  FN_ANALOG_SELECT  = 8'h1A;

  // Settings that steer the routing
  typedef struct packed {
    logic [31:0] port_one_function_select;
    logic [31:0] port_two_function_select;
    logic [3:0]  lower_bits_invert_select;
    logic [3:0]  upper_bits_invert_select;
  } vism_cfg_t;

endpackage

// >>> vism_servo_model.sv
// Servo-side consumer of the routed input functions
`timescale 1ns/1ps
module vism_servo_model (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [vism_pkg::NUM_FUNC-1:0] func_out,
  output logic      [vism_pkg::NUM_FUNC-1:0] servo_func
);
  //----------------------------------------------------------------
  // Capture
  //----------------------------------------------------------------
  // Samples the function levels once a cycle, as the servo loop does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_func <= '0;
    end else begin
      servo_func <= func_out;
    end
  end
endmodule

// >>> virtual_input_signal_mapper_tb.sv
// Self-checking bench for the virtual input signal mapper
`timescale 1ns/1ps
module virtual_input_signal_mapper_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [7:0]  virt_in;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic [26:0] func_out;
  logic [26:0] servo_func;
  int          mismatches;
  int          num_checks;
  int          cycles;
  // Columns: port one, port two, lower invert, upper invert, virt_in, expected functions
  logic [31:0] rows [8][6] = '{
    '{32'h13121110, 32'h0F0E0D0C, 32'h0, 32'h0, 32'hFF, 32'h000FF000},
    '{32'h13121110, 32'h0F0E0D0C, 32'hF, 32'h0, 32'h00, 32'h000F0000},
    '{32'h13121110, 32'h0F0E0D0C, 32'h0, 32'hF, 32'h00, 32'h0000F000},
    '{32'h03020100, 32'h1A1A1A1A, 32'h0, 32'h0, 32'h1F, 32'h0400000F},
    '{32'h1B1B1B1B, 32'h07060504, 32'h2, 32'h0, 32'hF0, 32'h000000F0},
    '{32'h1A1A1A1A, 32'h19181716, 32'h0, 32'hF, 32'h01, 32'h07C00000},
    '{32'h1A1B1B00, 32'h1B1B1B02, 32'h9, 32'h0, 32'h11, 32'h04000004},
    '{32'h0B0A0908, 32'h15141918, 32'h0, 32'h0, 32'hFF, 32'h03300F00}};
  logic [31:0] rst_val [4] = '{32'h13121110, 32'h0F0E0D0C, 32'h0, 32'h0};

  vism_mapper u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .virt_in(virt_in), .func_out(func_out));
  vism_servo_model u_servo (.pclk(pclk), .presetn(presetn), .func_out(func_out), .servo_func(servo_func));

  //----------------------------------------------------------------
  // Clock, timeout and checking tasks
  //----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic results;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; psel stays high so a setup may follow at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
  endtask

  //----------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    virt_in = 8'hFF;
    repeat (8) @(posedge pclk);
    chk({5'h00, func_out}, 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk({5'h00, func_out}, 32'h000FF000);
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, rst_val[i]);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h00, rows[i][0]);
      apb(1'b1, 8'h04, rows[i][1]);
      apb(1'b1, 8'h08, rows[i][2]);
      apb(1'b1, 8'h0C, rows[i][3]);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, rows[i][0]);
      chk_flag(er, 1'b0);
      psel    <= 1'b0;
      virt_in <= rows[i][4][7:0];
      repeat (3) @(posedge pclk);
      chk({5'h00, servo_func}, rows[i][5]);
    end
    // Setting change lands one cycle after the write edge
    apb(1'b1, 8'h08, 32'h1);
    psel <= 1'b0;
    #1 chk({5'h00, func_out}, 32'h03300F00);
    @(posedge pclk);
    #1 chk({5'h00, func_out}, 32'h03300E00);
    @(posedge pclk);
    // Refused accesses leave the settings alone
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk_flag(er, 1'b1);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk_flag(er, 1'b1);
    apb(1'b1, 8'h24, 32'h1A1A1A1A);
    chk_flag(er, 1'b1);
    apb(0, 8'h00, 32'h0);
    chk(rd, 32'h0B0A0908);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h03300E00);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h000000FF);
    // Reset in mid-run restores the settings
    psel    <= 1'b0;
    presetn <= 1'b0;
    @(posedge pclk);
    #1 chk({5'h00, func_out}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk({5'h00, func_out}, 32'h000FF000);
    @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, rst_val[2]);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, rst_val[1]);
    psel <= 1'b0;
    @(posedge pclk);
    results();
  end
endmodule
